// [irqnv_asserts.sv]
// Port checker for the interrupt and key store verify block.
// Assumes a bind from the bench top file and a single clock.
module irqnv_asserts
    import irqnv_pkg::*;
#(
    parameter int DIG_W = 160
)(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [7:0]       adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic             hash_start_o,
    input wire logic [DIG_W-1:0] hash_digest_i,
    input wire logic [DIG_W-1:0] stored_digest_i,
    input wire logic             irq_o
);
    // ****************************************************************
    // Shadow of the enable register
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] en_ff;
    logic [7:0] nxt_en;
    logic       rd;
    assign rd = ack_o && !we_i;
    always_comb
    begin
        nxt_en = en_ff;
        // Follow the take edge, as the design does, not the ack
        if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
            && adr_i == IRQNV_IDX_ENABLE)
            nxt_en = dat_i[7:0] & IRQNV_ENABLE_RW;
    end
    always_ff @(posedge clk_i) en_ff <= rst_i ? 8'h00 : nxt_en;
    sequence s_start_wr;
        ack_o && we_i && adr_i == IRQNV_IDX_VERIFY && dat_i[2];
    endsequence
    sequence s_vfy_rd;
        rd && adr_i == IRQNV_IDX_VERIFY && dat_o[6];
    endsequence
    property p_ack_take;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    property p_glb_gate;
        irq_o |-> en_ff[IRQNV_BIT_GLOBAL];
    endproperty
    property p_en_read;
        rd && adr_i == IRQNV_IDX_ENABLE |-> dat_o == {24'h0, en_ff};
    endproperty
    property p_sts_read;
        rd && adr_i == IRQNV_IDX_STATUS |-> dat_o[4:1] == 4'h0
            && dat_o[0] == |(dat_o[7:5] & en_ff[7:5]);
    endproperty
    property p_vfy_done;
        s_vfy_rd |-> !dat_o[2] && dat_o[4:3] == 2'h0;
    endproperty
    property p_vfy_ok;
        s_vfy_rd |-> dat_o[7] == (hash_digest_i == stored_digest_i);
    endproperty
    property p_start;
        s_start_wr |-> ##[1:3] hash_start_o;
    endproperty
    property p_rst;
        $fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0;
    endproperty
    a_ack_take: assert property (p_ack_take)
        else $error("no ack after request");
    a_glb_gate: assert property (p_glb_gate)
        else $error("irq without global enable");
    a_en_read: assert property (p_en_read)
        else $error("enable readback wrong");
    a_sts_read: assert property (p_sts_read)
        else $error("status summary wrong");
    a_vfy_done: assert property (p_vfy_done)
        else $error("start not cleared at finish");
    a_vfy_ok: assert property (p_vfy_ok)
        else $error("verify result wrong");
    a_start: assert property (p_start)
        else $error("verify did not start");
    a_rst: assert property (p_rst)
        else $error("outputs not idle after reset");
endmodule // irqnv_asserts

// [irqnv_ctrl.sv]
// Interrupt enables, status and key store verify control.
// Assumes a key memory port answering one word per cycle and an
// external hash engine with start/done; source events are pins.
module irqnv_ctrl
    import irqnv_pkg::*;
#(
    parameter int KEY_W   = 32,
    parameter int KEY_N   = IRQNV_KEY_COUNT,
    parameter int DIG_W   = 160
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic              ind_access_done_i,
    input  wire logic              receiver_present_i,
    input  wire logic              receiver_lock_i,
    input  wire logic              downstream_irq_i,
    output logic      [7:0]        key_addr_o,
    output logic                   key_rd_o,
    input  wire logic [KEY_W-1:0]  key_data_i,
    output logic                   hash_start_o,
    output logic      [KEY_W-1:0]  hash_data_o,
    output logic                   hash_valid_o,
    input  wire logic              hash_done_i,
    input  wire logic [DIG_W-1:0]  hash_digest_i,
    input  wire logic [DIG_W-1:0]  stored_digest_i,
    output logic                   irq_o,
    output logic                   pending_irq_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]      s1;
        logic [1:0]      s2;
        logic            rxf_prev;
        logic            ack;
        logic [31:0]     rdata;
        logic [7:0]      enable;
        logic [7:0]      status;
        logic [7:0]      verify;
        logic [7:0]      config_r;
        logic [IRQNV_EVENTS-1:0] pend;
        logic [IRQNV_EVENTS-1:0] mask;
        irqnv_state_type fsm;
        logic [7:0]      kidx;
        logic            rd_pend;
        logic            hstart;
        logic            hvalid;
        logic [KEY_W-1:0] hdata;
    } irqnv_regs_type;

    irqnv_regs_type r_ff;
    irqnv_regs_type nxt_r;

    logic [7:0] wmask;
    logic       wr;
    logic       rd;
    logic       rxf_cond;
    logic       rxf_evt;
    logic       vfy_evt;
    logic [IRQNV_EVENTS-1:0] ev;

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wv,
                                         input logic [7:0] rwm);
        merge = (old & ~rwm) | (wv & rwm);
    endfunction

    // Receiver pins are asynchronous: two flops, then only s2 is read
    always_comb
    begin
        wmask    = sel_i[0] ? 8'hff : 8'h00;
        wr       = cyc_i && stb_i && we_i && !r_ff.ack;
        rd       = cyc_i && stb_i && !we_i && !r_ff.ack;
        rxf_cond = r_ff.config_r[IRQNV_BIT_SEL] ?
                   (r_ff.s2[0] && r_ff.s2[1]) : r_ff.s2[0];
        rxf_evt  = rxf_cond && !r_ff.rxf_prev;
        vfy_evt  = 1'b0;
        ev       = '0;

        nxt_r          = r_ff;
        nxt_r.s1       = {receiver_lock_i, receiver_present_i};
        nxt_r.s2       = r_ff.s1;
        nxt_r.rxf_prev = rxf_cond;
        nxt_r.ack      = cyc_i && stb_i && !r_ff.ack;
        nxt_r.hstart   = 1'b0;
        nxt_r.hvalid   = 1'b0;
        nxt_r.rd_pend  = 1'b0;

        // ************************************************************
        // Verify sequencer
        // ************************************************************
        unique case (r_ff.fsm)
            IRQNV_IDLE:
            begin
                if (r_ff.verify[IRQNV_BIT_START])
                begin
                    nxt_r.verify[IRQNV_BIT_FIN] = 1'b0;
                    nxt_r.verify[IRQNV_BIT_OK]  = 1'b0;
                    nxt_r.kidx   = 8'h00;
                    nxt_r.hstart = 1'b1;
                    nxt_r.fsm    = IRQNV_READ;
                end
            end
            IRQNV_READ:
            begin
                // One key per two cycles: read then feed hash
                if (r_ff.rd_pend)
                begin
                    nxt_r.hdata  = key_data_i;
                    nxt_r.hvalid = 1'b1;
                    if (r_ff.kidx == 8'(KEY_N - 1))
                        nxt_r.fsm = IRQNV_HASH;
                    else
                        nxt_r.kidx = r_ff.kidx + 8'h01;
                end
                else
                    nxt_r.rd_pend = 1'b1;
            end
            IRQNV_HASH:
            begin
                if (hash_done_i)
                    nxt_r.fsm = IRQNV_CMP;
            end
            IRQNV_CMP:
            begin
                nxt_r.verify[IRQNV_BIT_OK] =
                    (hash_digest_i == stored_digest_i);
                nxt_r.verify[IRQNV_BIT_FIN]   = 1'b1;
                nxt_r.verify[IRQNV_BIT_START] = 1'b0;
                vfy_evt   = 1'b1;
                nxt_r.fsm = IRQNV_IDLE;
            end
        endcase

        // ************************************************************
        // Source status, sticky until the source is disabled
        // ************************************************************
        if (ind_access_done_i)
            nxt_r.status[IRQNV_BIT_IND] = 1'b1;
        if (rxf_evt)
            nxt_r.status[IRQNV_BIT_RXF] = 1'b1;
        if (downstream_irq_i && r_ff.enable[IRQNV_BIT_DSR])
            nxt_r.status[IRQNV_BIT_DSR] = 1'b1;

        // ************************************************************
        // Register writes
        // ************************************************************
        if (wr)
        begin
            unique case (adr_i)
                IRQNV_IDX_ENABLE:
                    nxt_r.enable = merge(r_ff.enable, dat_i[7:0],
                                         wmask & IRQNV_ENABLE_RW);
                IRQNV_IDX_VERIFY:
                    if (sel_i[0])
                    begin
                        if (dat_i[IRQNV_BIT_START] && r_ff.fsm == IRQNV_IDLE)
                            nxt_r.verify[IRQNV_BIT_START] = 1'b1;
                        nxt_r.verify[IRQNV_BIT_SPARE] = dat_i[IRQNV_BIT_SPARE];
                    end
                IRQNV_IDX_CONFIG:
                    nxt_r.config_r = merge(r_ff.config_r, dat_i[7:0],
                                           wmask & IRQNV_CFG_RW);
                IRQNV_IDX_MASK:
                    if (sel_i[0])
                        nxt_r.mask = dat_i[IRQNV_EVENTS-1:0];
                IRQNV_IDX_PENDING:
                    if (sel_i[0])
                        nxt_r.pend = r_ff.pend & ~dat_i[IRQNV_EVENTS-1:0];
                default:
                    nxt_r.ack = nxt_r.ack;
            endcase
        end
        // Disabled sources drop their flag; status is read only
        nxt_r.status = nxt_r.status & ({nxt_r.enable[7:1], 1'b1});

        // Global status follows enabled and flagged sources
        nxt_r.status[IRQNV_BIT_GLOBAL] =
            |(nxt_r.status & nxt_r.enable & IRQNV_SRC_MASK);

        // Sticky pending bits; a new event beats the clear
        ev[IRQNV_EV_VFY] = vfy_evt;
        ev[IRQNV_EV_IND] = ind_access_done_i;
        ev[IRQNV_EV_RXF] = rxf_evt;
        ev[IRQNV_EV_DSR] = downstream_irq_i;
        nxt_r.pend = nxt_r.pend | ev;

        // ************************************************************
        // Read data
        // ************************************************************
        nxt_r.rdata = 32'h0000_0000;
        if (rd)
        begin
            unique case (adr_i)
                IRQNV_IDX_ENABLE:  nxt_r.rdata[7:0] = r_ff.enable;
                IRQNV_IDX_STATUS:  nxt_r.rdata[7:0] = r_ff.status;
                IRQNV_IDX_VERIFY:  nxt_r.rdata[7:0] = r_ff.verify;
                IRQNV_IDX_CONFIG:  nxt_r.rdata[7:0] = r_ff.config_r;
                IRQNV_IDX_MASK:
                    nxt_r.rdata[IRQNV_EVENTS-1:0] = r_ff.mask;
                IRQNV_IDX_PENDING:
                    nxt_r.rdata[IRQNV_EVENTS-1:0] = r_ff.pend;
                default:           nxt_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_ff          <= '0;
            r_ff.enable   <= IRQNV_RESET_VAL;
            r_ff.status   <= IRQNV_RESET_VAL;
            r_ff.verify   <= IRQNV_RESET_VAL;
            r_ff.config_r <= IRQNV_RESET_VAL;
            r_ff.fsm      <= IRQNV_IDLE;
        end
        else
            r_ff <= nxt_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign dat_o         = r_ff.rdata;
    assign ack_o         = r_ff.ack;
    assign key_addr_o    = r_ff.kidx;
    assign key_rd_o      = (r_ff.fsm == IRQNV_READ) && !r_ff.rd_pend;
    assign hash_start_o  = r_ff.hstart;
    assign hash_data_o   = r_ff.hdata;
    assign hash_valid_o  = r_ff.hvalid;
    assign irq_o         = r_ff.enable[IRQNV_BIT_GLOBAL] &&
                           r_ff.status[IRQNV_BIT_GLOBAL];
    assign pending_irq_o = |(r_ff.pend & r_ff.mask);
endmodule // irqnv_ctrl

// [irqnv_ctrl_tb.sv]
// Self-checking bench for the interrupt and verify block.
// Assumes the package, design, checker and key store model.
module irqnv_ctrl_tb;
    import irqnv_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals, design and model
    // ****************************************************************
    localparam int KN = 4;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bad = 0;
    logic ind = 0, pres = 0, lock = 0, dsr = 0, ack, kr, hs, hv, hd;
    logic irq, pirq;
    logic [7:0]   adr = 8'h00, ka, keys, q;
    logic [3:0]   sel = 4'h0;
    logic [31:0]  wdat = 32'h0, rdat, kd, hdat;
    logic [159:0] dg, sd;
    int mismatches = 0, n_tests = 0, cycles = 0;
    irqnv_ctrl #(.KEY_N(KN)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .ind_access_done_i(ind),
        .receiver_present_i(pres), .receiver_lock_i(lock),
        .downstream_irq_i(dsr), .key_addr_o(ka), .key_rd_o(kr),
        .key_data_i(kd), .hash_start_o(hs), .hash_data_o(hdat),
        .hash_valid_o(hv), .hash_done_i(hd), .hash_digest_i(dg),
        .stored_digest_i(sd), .irq_o(irq), .pending_irq_o(pirq));
    irqnv_keystore #(.KEY_N(KN)) ks_u (.clk_i(clk_i), .rst_i(rst_i),
        .key_addr_i(ka), .key_rd_i(kr), .hash_start_i(hs),
        .hash_valid_i(hv), .bad_i(bad), .key_data_o(kd),
        .hash_done_o(hd), .hash_digest_o(dg), .stored_digest_o(sd),
        .keys_o(keys));
    always #5 clk_i = ~clk_i;
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Each hashed word must be the key at the model's running index
    always @(posedge clk_i)
    begin
        if (hv === 1'b1)
        begin
            n_tests++;
            if (hdat !== 32'(keys))
            begin
                mismatches++;
                $display("BAD hash_data exp %h got %h", 32'(keys), hdat);
            end
        end
    end
    // One classic cycle; waits for ack, never assumes a latency
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
        q = rdat[7:0];
        chk("ack", 8'h01, {7'h0, ack});
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task pin(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("enable", IRQNV_IDX_ENABLE, 8'h00);
        rdc("status", IRQNV_IDX_STATUS, 8'h00);
        rdc("verify", IRQNV_IDX_VERIFY, 8'h00);
        rdc("unmapped", 8'h10, 8'h00);
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'hff);
        rdc("enable", IRQNV_IDX_ENABLE, 8'he1);
        xfer(1'b1, IRQNV_IDX_STATUS, 8'hff);
        rdc("status", IRQNV_IDX_STATUS, 8'h00);
        ind <= 1'b1;
        @(posedge clk_i);
        ind <= 1'b0;
        rdc("status", IRQNV_IDX_STATUS, 8'h81);
        pin("irq", 1'b1, irq);
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'he0);
        @(posedge clk_i);
        pin("irq", 1'b0, irq);
        dsr <= 1'b1;
        repeat (2) @(posedge clk_i);
        dsr <= 1'b0;
        rdc("status", IRQNV_IDX_STATUS, 8'ha1);
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'hc0);
        dsr <= 1'b1;
        repeat (2) @(posedge clk_i);
        dsr <= 1'b0;
        rdc("status", IRQNV_IDX_STATUS, 8'h81);
        xfer(1'b1, IRQNV_IDX_CONFIG, 8'hff);
        rdc("config", IRQNV_IDX_CONFIG, 8'h02);
        pres <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdc("status", IRQNV_IDX_STATUS, 8'h81);
        lock <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdc("status", IRQNV_IDX_STATUS, 8'hc1);
        // Select zero: presence alone must raise the detect flag
        pres <= 1'b0;
        lock <= 1'b0;
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'h80);
        xfer(1'b1, IRQNV_IDX_CONFIG, 8'h00);
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'hc0);
        rdc("status", IRQNV_IDX_STATUS, 8'h81);
        pres <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdc("status", IRQNV_IDX_STATUS, 8'hc1);
        xfer(1'b1, IRQNV_IDX_ENABLE, 8'hc1);
        @(posedge clk_i);
        pin("irq", 1'b1, irq);
        xfer(1'b1, IRQNV_IDX_MASK, 8'h0f);
        @(posedge clk_i);
        pin("pending", 1'b1, pirq);
        rdc("mask", IRQNV_IDX_MASK, 8'h0f);
        rdc("pending", IRQNV_IDX_PENDING, 8'h0e);
        xfer(1'b1, IRQNV_IDX_PENDING, 8'h0f);
        @(posedge clk_i);
        pin("pending", 1'b0, pirq);
        for (int i = 0; i < 2; i++)
        begin
            bad <= i[0];
            xfer(1'b1, IRQNV_IDX_VERIFY, i ? 8'h3c : 8'h04);
            for (int n = 0; n < 40 && q[6] !== 1'b1; n++)
                xfer(1'b0, IRQNV_IDX_VERIFY, 8'h00);
            chk("verify", i ? 8'h60 : 8'hc0, q);
            chk("keys", 8'(KN), keys);
        end
        rdc("pending", IRQNV_IDX_PENDING, 8'h01);
        pin("pending", 1'b1, pirq);
        end_of_test();
    end
endmodule // irqnv_ctrl_tb
bind irqnv_ctrl irqnv_asserts #(.DIG_W(DIG_W)) chk_u (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .hash_start_o, .hash_digest_i, .stored_digest_i, .irq_o);

// [irqnv_keystore.sv]
// Model of the key memory and hash engine beside the block.
// Assumes one key index per read strobe and one valid per key.
module irqnv_keystore #(
    parameter int KEY_W = 32,
    parameter int KEY_N = 4,
    parameter int DIG_W = 160,
    parameter int SLOW  = 3
)(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       key_addr_i,
    input  wire logic             key_rd_i,
    input  wire logic             hash_start_i,
    input  wire logic             hash_valid_i,
    input  wire logic             bad_i,
    output logic      [KEY_W-1:0] key_data_o,
    output logic                  hash_done_o,
    output logic      [DIG_W-1:0] hash_digest_o,
    output logic      [DIG_W-1:0] stored_digest_o,
    output logic      [7:0]       keys_o
);
    // ****************************************************************
    // Key data, key count and a slow hash answer
    // ****************************************************************
    logic [7:0] wait_ff;
    always_ff @(posedge clk_i)
    begin
        // Stale data toggles so a late sample is never lucky
        key_data_o <= key_rd_i ? KEY_W'(key_addr_i) : ~key_data_o;
        hash_done_o <= (wait_ff == 8'(SLOW));
        if (rst_i || hash_start_i)
        begin
            keys_o  <= 8'h00;
            wait_ff <= 8'h00;
        end
        else
        begin
            if (hash_valid_i)
                keys_o <= keys_o + 8'h01;
            if (keys_o == 8'(KEY_N) && wait_ff <= 8'(SLOW))
                wait_ff <= wait_ff + 8'h01;
        end
    end
    assign hash_digest_o   = {(DIG_W/8){8'h5a}};
    assign stored_digest_o = bad_i ? ~hash_digest_o : hash_digest_o;
endmodule // irqnv_keystore

// [irqnv_pkg.sv]
// Constants shared by the interrupt and key store verify block.
// Assumes a classic Wishbone slave with byte-wide registers per word.
package irqnv_pkg;
    // ****************************************************************
    // Register map (word addresses on a 32-bit bus, data in bits 7:0)
    // ****************************************************************
    localparam logic [7:0] IRQNV_IDX_ENABLE  = 8'hc6;
    localparam logic [7:0] IRQNV_IDX_STATUS  = 8'hc7;
    localparam logic [7:0] IRQNV_IDX_VERIFY  = 8'hc8;
    localparam logic [7:0] IRQNV_IDX_CONFIG  = 8'hc2;
    localparam logic [7:0] IRQNV_IDX_MASK    = 8'hc9;
    localparam logic [7:0] IRQNV_IDX_PENDING = 8'hca;
    localparam logic [7:0] IRQNV_RESET_VAL   = 8'h00;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int IRQNV_BIT_IND    = 7;
    localparam int IRQNV_BIT_RXF    = 6;
    localparam int IRQNV_BIT_DSR    = 5;
    localparam int IRQNV_BIT_GLOBAL = 0;
    localparam int IRQNV_BIT_OK     = 7;
    localparam int IRQNV_BIT_FIN    = 6;
    localparam int IRQNV_BIT_SPARE  = 5;
    localparam int IRQNV_BIT_START  = 2;
    localparam int IRQNV_BIT_SEL    = 1;
    localparam logic [7:0] IRQNV_ENABLE_RW = 8'he1;
    localparam logic [7:0] IRQNV_SRC_MASK  = 8'he0;
    localparam logic [7:0] IRQNV_CFG_RW    = 8'h02;
    // Pending/mask layout: 0 verify done, 1..3 sources
    localparam int IRQNV_EV_VFY = 0;
    localparam int IRQNV_EV_IND = 1;
    localparam int IRQNV_EV_RXF = 2;
    localparam int IRQNV_EV_DSR = 3;
    localparam int IRQNV_EVENTS = 4;
    // ****************************************************************
    // Verify sequencer
    // ****************************************************************
    localparam int IRQNV_KEY_COUNT = 16;
    typedef enum logic [3:0] {
        IRQNV_IDLE = 4'b0001,
        IRQNV_READ = 4'b0010,
        IRQNV_HASH = 4'b0100,
        IRQNV_CMP  = 4'b1000
    } irqnv_state_type;
endpackage
